// ---- rtl/sfm_defines.svh ----
// constants for the supply fault safety monitor
`ifndef SFM_DEFINES_SVH
`define SFM_DEFINES_SVH
`define SFM_CLK_MHZ        200
`define SFM_OV_DGL_NS      10000
`define SFM_UV_DGL_NS      10000
`define SFM_CPF_DGL_NS     10000
`define SFM_PIN_DGL_CYC    4
`define SFM_PD_REDUCED     4'h1
`define SFM_STAT_OVF       0
`define SFM_STAT_UVF       1
`define SFM_STAT_CPF       2
`define SFM_STAT_RCF       3
`define SFM_STAT_W         4
`endif

// ---- rtl/sfm_pkg.sv ----
// types of the supply fault safety monitor
package sfm_pkg;
	typedef enum logic [1:0] {SFM_SLEEP, SFM_NORMAL, SFM_FAILSAFE} sfm_mode_e;
endpackage

// ---- rtl/sfm_deglitch.sv ----
// fault de-glitch counter: output rises after a steady run of the condition
`timescale 1ns/1ps
module sfm_deglitch #(
	parameter int COUNT = 2000
) (
	// clock
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic ce,
	// condition
	input  wire logic cond,
	output logic      hit
);
	localparam int W = $clog2(COUNT + 1);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         hit_q;
	logic         hit_d;

	always_comb begin
		cnt_d = cnt_q;
		hit_d = hit_q;
		if (!cond) begin
			cnt_d = '0;
			hit_d = 1'b0;
		end else if (cnt_q == W'(COUNT - 1)) begin
			hit_d = 1'b1;
		end else begin
			cnt_d = cnt_q + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q <= '0;
			hit_q <= 1'b0;
		end else if (ce) begin
			cnt_q <= cnt_d;
			hit_q <= hit_d;
		end
	end

	assign hit = hit_q;
endmodule

// ---- rtl/sfm_monitor.sv ----
// supply fault and failsafe supervision of a four channel gate pre-driver
`timescale 1ns/1ps
`include "sfm_defines.svh"
module sfm_monitor #(
	parameter int CH     = 4,
	parameter int OV_CYC = (`SFM_OV_DGL_NS * `SFM_CLK_MHZ) / 1000,
	parameter int UV_CYC = (`SFM_UV_DGL_NS * `SFM_CLK_MHZ) / 1000,
	parameter int CP_CYC = (`SFM_CPF_DGL_NS * `SFM_CLK_MHZ) / 1000
) (
	// clock
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire logic                   ce,
	// pins from outside the clock domain
	input  wire logic                   reset_in_n,
	input  wire logic                   fail_input,
	// analog comparator levels
	input  wire logic                   supply_ov,
	input  wire logic                   supply_ov_shutdown_level,
	input  wire logic                   supply_uv,
	input  wire logic                   logic_por,
	input  wire logic                   pump_fail,
	input  wire logic [CH-1:0]          half_bridge_node,
	// serial link front end
	input  wire logic                   serial_fail_cond,
	input  wire logic                   toggle_check_bit,
	input  wire logic                   status_read,
	input  wire logic                   restart_req,
	// commanded driver control
	input  wire logic [CH-1:0]          cmd_high,
	input  wire logic [CH-1:0]          cmd_low,
	input  wire logic [CH-1:0]          cmd_pwm,
	input  wire logic [CH-1:0]          test_cur_en,
	input  wire logic [3:0]             pulldown_setting,
	// gate drive and supply control
	output logic      [CH-1:0]          high_side_gate_out,
	output logic      [CH-1:0]          low_side_gate_out,
	output logic      [CH-1:0]          test_cur_out,
	output logic      [3:0]             pulldown_out,
	output logic                        pump_on,
	output logic                        switched_pump_output,
	output logic                        regs_clear,
	// status
	output logic      [`SFM_STAT_W-1:0] device_status_reg,
	output logic      [2*CH-1:0]        switching_status_reg,
	output logic      [CH-1:0]          node_status_reg,
	output logic                        comm_ok_bit,
	output logic      [1:0]             mode
);
	// ==========================================
	// pin synchronisers and digital de-glitch
	// ==========================================
	logic [2:0] rst_sy_q;
	logic [2:0] fail_sy_q;
	logic [2:0] tog_sy_q;
	logic       rst_f_q;
	logic       fail_f_q;
	logic       tog_f_q;
	logic       tog_prev_q;
	logic       rst_prev_q;
	logic [1:0] rst_c_q;
	logic [1:0] fail_c_q;
	logic       rst_f_d;
	logic       fail_f_d;
	logic [1:0] rst_c_d;
	logic [1:0] fail_c_d;

	// a stable level counts only after a few agreeing samples
	function automatic logic [2:0] filt(input logic s2, input logic s3, input logic f, input logic [1:0] c);
		logic [1:0] n;
		n = (s2 == s3 && s3 != f) ? c + 2'h1 : 2'h0;
		if (n == 2'(`SFM_PIN_DGL_CYC - 1))
			return {s3, 2'h0};
		return {f, n};
	endfunction

	always_comb begin
		{rst_f_d, rst_c_d}   = filt(rst_sy_q[1], rst_sy_q[2], rst_f_q, rst_c_q);
		{fail_f_d, fail_c_d} = filt(fail_sy_q[1], fail_sy_q[2], fail_f_q, fail_c_q);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rst_sy_q   <= 3'h0;
			fail_sy_q  <= 3'h0;
			tog_sy_q   <= 3'h0;
			rst_f_q    <= 1'b0;
			fail_f_q   <= 1'b0;
			rst_c_q    <= 2'h0;
			fail_c_q   <= 2'h0;
			tog_f_q    <= 1'b0;
			tog_prev_q <= 1'b0;
			rst_prev_q <= 1'b0;
		end else if (ce) begin
			rst_sy_q   <= {rst_sy_q[1:0], reset_in_n};
			fail_sy_q  <= {fail_sy_q[1:0], fail_input};
			tog_sy_q   <= {tog_sy_q[1:0], toggle_check_bit};
			rst_f_q    <= rst_f_d;
			fail_f_q   <= fail_f_d;
			rst_c_q    <= rst_c_d;
			fail_c_q   <= fail_c_d;
			if (tog_sy_q[1] == tog_sy_q[2])
				tog_f_q <= tog_sy_q[2];
			tog_prev_q <= tog_f_q;
			rst_prev_q <= rst_f_q;
		end
	end

	wire toggled = tog_f_q ^ tog_prev_q;

	// ==========================================
	// fault de-glitch timers
	// ==========================================
	logic ov_hit;
	logic uv_hit;
	logic cp_hit;

	sfm_deglitch #(.COUNT(OV_CYC)) u_ov (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.cond  (supply_ov),
		.hit   (ov_hit)
	);
	sfm_deglitch #(.COUNT(UV_CYC)) u_uv (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.cond  (supply_uv),
		.hit   (uv_hit)
	);
	// pump fail is ignored above the shutdown level
	sfm_deglitch #(.COUNT(CP_CYC)) u_cp (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.cond  (pump_fail & ~supply_ov_shutdown_level),
		.hit   (cp_hit)
	);

	// ==========================================
	// operating mode and latched faults
	// ==========================================
	sfm_pkg::sfm_mode_e mode_q;
	sfm_pkg::sfm_mode_e mode_d;
	logic               hs_off_q;
	logic               hs_off_d;
	logic               all_off_q;
	logic               all_off_d;
	logic [`SFM_STAT_W-1:0] stat_q;
	logic [`SFM_STAT_W-1:0] stat_d;
	logic               clr_q;
	logic               clr_d;

	wire fs_cond = rst_f_q & (serial_fail_cond | fail_f_q);
	// only a fresh rising wake level leaves sleep, so a supply reset needs a new wake
	wire woke    = rst_f_q & ~rst_prev_q;

	always_comb begin
		mode_d    = mode_q;
		hs_off_d  = hs_off_q;
		all_off_d = all_off_q;
		stat_d    = stat_q;
		clr_d     = 1'b0;
		// reading the status unlatches flags; a fault in the same cycle wins
		if (status_read)
			stat_d = '0;
		if (restart_req && !status_read && stat_q[`SFM_STAT_OVF] == 1'b0 && stat_q[`SFM_STAT_UVF] == 1'b0
			&& stat_q[`SFM_STAT_CPF] == 1'b0) begin
			hs_off_d  = 1'b0;
			all_off_d = 1'b0;
		end
		if (supply_ov)
			stat_d[`SFM_STAT_OVF] = 1'b1;
		if (ov_hit)
			hs_off_d = 1'b1;
		if (uv_hit) begin
			all_off_d              = 1'b1;
			stat_d[`SFM_STAT_UVF] = 1'b1;
		end
		if (cp_hit) begin
			all_off_d              = 1'b1;
			stat_d[`SFM_STAT_CPF] = 1'b1;
		end
		case (mode_q)
			sfm_pkg::SFM_SLEEP: begin
				if (woke) begin
					mode_d    = sfm_pkg::SFM_NORMAL;
					clr_d     = 1'b1;
					stat_d    = '0;
					hs_off_d  = 1'b0;
					all_off_d = 1'b0;
					stat_d[`SFM_STAT_RCF] = 1'b1;
				end
			end
			sfm_pkg::SFM_NORMAL: begin
				if (!rst_f_q)
					mode_d = sfm_pkg::SFM_SLEEP;
				else if (fs_cond)
					mode_d = sfm_pkg::SFM_FAILSAFE;
			end
			sfm_pkg::SFM_FAILSAFE: begin
				if (!rst_f_q)
					mode_d = sfm_pkg::SFM_SLEEP;
				else if (toggled && !fail_f_q && !serial_fail_cond) begin
					mode_d    = sfm_pkg::SFM_NORMAL;
					clr_d     = 1'b1;
					stat_d    = '0;
					hs_off_d  = 1'b0;
					all_off_d = 1'b0;
					stat_d[`SFM_STAT_RCF] = 1'b1;
				end
			end
			default: mode_d = sfm_pkg::SFM_SLEEP;
		endcase
		if (logic_por) begin
			mode_d = sfm_pkg::SFM_SLEEP;
			clr_d  = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mode_q    <= sfm_pkg::SFM_SLEEP;
			hs_off_q  <= 1'b0;
			all_off_q <= 1'b0;
			stat_q    <= '0;
			clr_q     <= 1'b0;
		end else if (ce) begin
			mode_q    <= mode_d;
			hs_off_q  <= hs_off_d;
			all_off_q <= all_off_d;
			stat_q    <= stat_d;
			clr_q     <= clr_d;
		end
	end

	// ==========================================
	// outputs
	// ==========================================
	// immediate paths: logic_por and failsafe conditions cut gates without a register stage
	wire normal = (mode_q == sfm_pkg::SFM_NORMAL) & ~logic_por & ~fs_cond;

	always_comb begin
		high_side_gate_out = (normal && !hs_off_q && !all_off_q) ? (cmd_high | cmd_pwm) : '0;
		low_side_gate_out  = (normal && !all_off_q) ? (cmd_low | cmd_pwm) : '0;
		test_cur_out       = (normal && !supply_ov && !all_off_q) ? test_cur_en : '0;
		pulldown_out       = supply_ov ? `SFM_PD_REDUCED : pulldown_setting;
		pump_on              = normal;
		switched_pump_output = normal;
	end

	logic [2*CH-1:0] sw_q;
	logic [CH-1:0]   node_q;
	logic            ok_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			sw_q   <= '0;
			node_q <= '0;
			ok_q   <= 1'b0;
		end else if (ce) begin
			sw_q   <= {high_side_gate_out | cmd_pwm, low_side_gate_out | cmd_pwm};
			node_q <= half_bridge_node;
			ok_q   <= rst_f_q & ~serial_fail_cond;
		end
	end

	assign regs_clear           = clr_q;
	assign device_status_reg    = stat_q;
	assign switching_status_reg = sw_q;
	assign node_status_reg      = node_q;
	assign comm_ok_bit          = ok_q;
	assign mode                 = mode_q;
endmodule

// ---- verification/sfm_monitor_asserts.sv ----
// concurrent checks on the supply fault monitor ports
`timescale 1ns/1ps
`include "sfm_defines.svh"
module sfm_monitor_asserts #(
	parameter int CH = 4
) (
	// clock
	input wire logic                   clk,
	input wire logic                   reset,
	// fault levels and other inputs
	input wire logic                   supply_ov,
	input wire logic                   supply_ov_shutdown_level,
	input wire logic                   supply_uv,
	input wire logic                   logic_por,
	input wire logic                   fail_input,
	input wire logic                   serial_fail_cond,
	input wire logic [CH-1:0]          half_bridge_node,
	input wire logic [3:0]             pulldown_setting,
	// outputs watched
	input wire logic [CH-1:0]          high_side_gate_out,
	input wire logic [CH-1:0]          low_side_gate_out,
	input wire logic [CH-1:0]          test_cur_out,
	input wire logic [3:0]             pulldown_out,
	input wire logic                   pump_on,
	input wire logic                   switched_pump_output,
	input wire logic [`SFM_STAT_W-1:0] device_status_reg,
	input wire logic [CH-1:0]          node_status_reg,
	input wire logic [1:0]             mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// hold lengths assume the shortened de-glitch counts of simulation
	sequence ov_held; supply_ov[*8]; endsequence
	sequence uv_held; (supply_uv && mode == 2'h1)[*8]; endsequence
	sequence fail_held; $rose(fail_input) ##1 fail_input[*8]; endsequence
	hs_ov_off_a: assert property (ov_held |-> high_side_gate_out == '0) else $error("high side on");
	test_cur_off_a: assert property (supply_ov |-> test_cur_out == '0) else $error("test current on");
	pulldown_sel_a: assert property (pulldown_out == (supply_ov ? 4'h1 : pulldown_setting))
		else $error("pull-down code");
	ov_flag_a: assert property (supply_ov && mode == 2'h1 |=> device_status_reg[0]) else $error("ov flag");
	pump_mask_a: assert property (supply_ov_shutdown_level && !device_status_reg[2] |=> !device_status_reg[2])
		else $error("pump flag not masked");
	uv_all_off_a: assert property (uv_held |-> high_side_gate_out == '0 && low_side_gate_out == '0 && device_status_reg[1])
		else $error("uv shutdown");
	uv_pump_on_a: assert property (supply_uv && mode == 2'h1 |-> pump_on && switched_pump_output)
		else $error("pump off in uv");
	por_sleep_a: assert property (logic_por |=> mode == 2'h0) else $error("no sleep");
	serial_fs_a: assert property (serial_fail_cond && mode == 2'h1 |-> ##[1:9] mode == 2'h2)
		else $error("no failsafe");
	node_live_a: assert property (1'b1 |=> node_status_reg == $past(half_bridge_node)) else $error("node bits");
	fail_exit_a: assert property (fail_held |-> ##[0:6] mode != 2'h1) else $error("fail input ignored");
	fs_gates_a: assert property (mode == 2'h2 |-> high_side_gate_out == '0 && low_side_gate_out == '0)
		else $error("gates on in failsafe");
	rcf_set_a: assert property (mode == 2'h1 && $past(mode) != 2'h1 |-> ##[0:1] device_status_reg[3])
		else $error("reset flag");
endmodule
bind sfm_monitor sfm_monitor_asserts #(.CH(CH)) chk_u (.*);

// ---- verification/sfm_mcu_model.sv ----
// supervising controller model: wake, toggle bit, status read and restart
`timescale 1ns/1ps
module sfm_mcu_model (
	input  wire logic clk,
	output logic      reset_in_n,
	output logic      toggle_check_bit,
	output logic      status_read,
	output logic      restart_req,
	output logic      serial_fail_cond
);
	initial begin
		{reset_in_n, toggle_check_bit, status_read, restart_req, serial_fail_cond} = 5'h00;
	end
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	// wake needs a fresh low to high edge on the pin
	task automatic wake();
		reset_in_n = 1'b0;
		repeat (10) step();
		reset_in_n = 1'b1;
	endtask
	task automatic toggle();
		toggle_check_bit = !toggle_check_bit;
	endtask
	// read first, restart two cycles later so the flags are already clear
	task automatic clear_restart(bit rd);
		if (rd) begin
			status_read = 1'b1;
			step();
			status_read = 1'b0;
			step();
		end
		restart_req = 1'b1;
		step();
		restart_req = 1'b0;
		step();
	endtask
	task automatic break_comm(bit on);
		serial_fail_cond = on;
	endtask
endmodule

// ---- verification/sfm_monitor_tb.sv ----
// self-checking bench of the supply fault monitor
`timescale 1ns/1ps
`include "sfm_defines.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
	$display("wrong value %s exp %h got %h", nm, ex, got); end end
module sfm_monitor_tb;
	logic       clk, reset, ce, fail_input, supply_ov, supply_ov_shutdown_level, supply_uv, logic_por, pump_fail;
	logic       reset_in_n, toggle_check_bit, status_read, restart_req, serial_fail_cond;
	logic [3:0] half_bridge_node, cmd_high, cmd_low, cmd_pwm, test_cur_en, high_side_gate_out, low_side_gate_out;
	logic [3:0] test_cur_out, node_status_reg, pulldown_setting, pulldown_out, device_status_reg;
	logic       pump_on, switched_pump_output, regs_clear, comm_ok_bit;
	logic [7:0] switching_status_reg;
	logic [1:0] mode;
	int         num_errors, n_tests, cyc;
	sfm_monitor #(.OV_CYC(4), .UV_CYC(4), .CP_CYC(4)) dut_u (.*);
	sfm_mcu_model mcu_u (.*);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = !clk;
	end
	// ==========================================================
	// helpers
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// pwm shows both switch bits of a channel as one
	function automatic logic [7:0] exp_sw(logic [3:0] hi, logic [3:0] lo, logic [3:0] pwm);
		return {hi | pwm, lo | pwm};
	endfunction
	task automatic wait_mode(logic [1:0] m);
		for (int i = 0; i < 30 && mode !== m; i++) tick(1);
	endtask
	task automatic end_sim();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			end_sim();
		end
	end
	// ==========================================================
	// scenarios
	initial begin
		{reset, ce} = 2'h3;
		{fail_input, supply_ov, supply_ov_shutdown_level, supply_uv, logic_por, pump_fail} = 6'h00;
		{half_bridge_node, cmd_high, cmd_low, cmd_pwm, test_cur_en, pulldown_setting} = 24'h000005;
		void'($urandom(32'hCCDB1A73));
		tick(4);
		reset = 1'b0;
		mcu_u.wake();
		wait_mode(2'h1);
		`CHK("rcf", 1'b1, device_status_reg[3])
		`CHK("clr", 1'b1, regs_clear)
		for (int i = 0; i < 20; i++) begin
			cmd_high = 4'($urandom);
			cmd_low = 4'($urandom) & ~cmd_high;
			cmd_pwm = 4'($urandom);
			half_bridge_node = 4'($urandom);
			test_cur_en = 4'($urandom);
			pulldown_setting = 4'($urandom);
			supply_ov_shutdown_level = 1'($urandom);
			tick(3);
			`CHK("sw", exp_sw(cmd_high, cmd_low, cmd_pwm), switching_status_reg)
			`CHK("node", half_bridge_node, node_status_reg)
			`CHK("tc", test_cur_en, test_cur_out)
			`CHK("pd", pulldown_setting, pulldown_out)
			`CHK("cpf", 1'b0, device_status_reg[2])
		end
		// a low enable must freeze the registered status
		ce = 1'b0;
		cmd_high = ~cmd_high;
		tick(3);
		`CHK("sw_hold", exp_sw(~cmd_high, cmd_low, cmd_pwm), switching_status_reg)
		ce = 1'b1;
		{cmd_pwm, cmd_high, cmd_low, test_cur_en, pulldown_setting} = 20'h0A5F9;
		supply_ov = 1'b1;
		#1;
		`CHK("pd", 4'h1, pulldown_out)
		`CHK("tc", 4'h0, test_cur_out)
		tick(10);
		`CHK("hs", 4'h0, high_side_gate_out)
		`CHK("ls", 4'h5, low_side_gate_out)
		`CHK("ovf", 1'b1, device_status_reg[0])
		supply_ov = 1'b0;
		mcu_u.clear_restart(1'b0);
		`CHK("pd", 4'h9, pulldown_out)
		`CHK("hs", 4'h0, high_side_gate_out)
		mcu_u.clear_restart(1'b1);
		`CHK("hs", 4'hA, high_side_gate_out)
		{supply_ov, supply_ov_shutdown_level, pump_fail} = 3'h7;
		tick(10);
		`CHK("cpf", 1'b0, device_status_reg[2])
		{supply_ov, supply_ov_shutdown_level} = 2'h0;
		tick(10);
		`CHK("cpf", 1'b1, device_status_reg[2])
		{pump_fail, supply_uv} = 2'h1;
		tick(10);
		`CHK("gates", 8'h00, {high_side_gate_out, low_side_gate_out})
		`CHK("uvf", 1'b1, device_status_reg[1])
		`CHK("pump", 2'h3, {pump_on, switched_pump_output})
		supply_uv = 1'b0;
		// let the registered fault hit drop before the read
		tick(1);
		mcu_u.clear_restart(1'b1);
		`CHK("gates", 8'hA5, {high_side_gate_out, low_side_gate_out})
		fail_input = 1'b1;
		wait_mode(2'h2);
		`CHK("mode", 2'h2, mode)
		`CHK("gates", 8'h00, {high_side_gate_out, low_side_gate_out})
		`CHK("pump", 2'h0, {pump_on, switched_pump_output})
		tick(3);
		fail_input = 1'b0;
		tick(12);
		mcu_u.toggle();
		wait_mode(2'h1);
		`CHK("mode", 2'h1, mode)
		`CHK("clr", 1'b1, regs_clear)
		mcu_u.break_comm(1'b1);
		wait_mode(2'h2);
		`CHK("mode", 2'h2, mode)
		`CHK("nm", 1'b0, comm_ok_bit)
		mcu_u.break_comm(1'b0);
		tick(2);
		mcu_u.toggle();
		wait_mode(2'h1);
		tick(12);
		`CHK("nm", 1'b1, comm_ok_bit)
		logic_por = 1'b1;
		tick(1);
		`CHK("mode", 2'h0, mode)
		logic_por = 1'b0;
		tick(3);
		`CHK("mode", 2'h0, mode)
		mcu_u.wake();
		wait_mode(2'h1);
		`CHK("mode", 2'h1, mode)
		end_sim();
	end
endmodule
